/* core/pcm_dbuf.sv */
`timescale 1ns/1ps
// ****************************************************************
// Double-buffered byte: software writes a holding stage, a transfer
// strobe copies it into the active stage
// ****************************************************************
module pcm_dbuf
    import pcm_pkg::*;
#(
    parameter int unsigned W = 8                 // Data width
)(
    input  wire logic         pclk,              // System clock
    input  wire logic         presetn,           // Async reset, active low
    input  wire logic         wr,                // Write holding stage
    input  wire logic [W-1:0] wdata,             // Write data
    input  wire logic         xfer,              // Copy hold to active
    output logic      [W-1:0] hold,              // Holding stage
    output logic      [W-1:0] active             // Active stage
);
    typedef struct packed {
        logic [W-1:0] hold;    // Software side
        logic [W-1:0] active;  // Match side
    } pcm_buf_s;

    pcm_buf_s st_r;            // Present state
    pcm_buf_s st_nxt;          // Next state

    // A transfer takes the old holding value when a write lands with it
    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            st_nxt.hold = wdata;
        end
        if (xfer) begin
            st_nxt.active = st_r.hold;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hold   = st_r.hold;
    assign active = st_r.active;

endmodule : pcm_dbuf

/* core/pcm_main_counter.sv */
// Register access over APB was decided locally.
`timescale 1ns/1ps
module pcm_main_counter
    import pcm_pkg::*;
(
    input  wire logic                      pclk,             // System clock, 200 MHz
    input  wire logic                      presetn,          // Async reset, active low
    input  wire logic                      psel,             // APB select
    input  wire logic                      penable,          // APB access phase
    input  wire logic                      pwrite,           // APB write
    input  wire logic [pcm_pkg::ADDR_W-1:0] paddr,           // APB byte address
    input  wire logic [31:0]               pwdata,           // APB write data
    input  wire logic                      idle_mode,        // Processor in idle
    input  wire logic                      comparator_event, // Comparator event pulse
    output logic      [31:0]               prdata,           // APB read data
    output logic                           pready,           // APB ready
    output logic                           pslverr,          // APB error
    output logic                           overflow_irq,     // Overflow request pulse
    output logic                           compare_irq       // Match request pulse
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pcm_byte_t   ctl;      // counter_mode_control
        pcm_byte_t   pcs;      // counter_clock_prescale
        logic [15:0] cnt;      // Main count
        pcm_byte_t   rlh;      // reload_high
        pcm_byte_t   rll;      // reload_low
        logic [15:0] snap;     // snapshot_high:snapshot_low
        logic [31:0] prdata;   // Read data latched at setup
        logic        pready;   // Ready in access phase
        logic        pslverr;  // Unmapped address seen
        logic        ovf_irq;  // Overflow request
        logic        cmp_irq;  // Match request
    } pcm_main_s;

    pcm_main_s   st_r;         // Present state
    pcm_main_s   st_nxt;       // Next state

    logic        run_w;        // Counting allowed now
    logic        tick_w;       // Prescaled tick
    logic        step_w;       // Counter advances this clock
    logic        ovf_w;        // Overflow on this step
    logic        xfer_w;       // Compare buffer transfer
    logic [1:0]  cmp_wr_w;     // Compare byte writes, [1] high
    logic [15:0] cmp_act_w;    // Compare active stage
    logic        setup_w;      // APB setup cycle
    logic        done_w;       // APB transfer completes
    logic        wr_w;         // Write completes
    logic        cl_rd_w;      // Low-byte read in its setup cycle

    // ************************************************************
    // Run, tick and overflow decode
    // ************************************************************
    // Enable gates everything; the idle stop bit only matters in idle
    assign run_w  = st_r.ctl[BIT_ENABLE] &&
                    !(idle_mode && st_r.ctl[BIT_IDLE_STOP]);
    assign step_w = tick_w && run_w;

    // Low-byte wrap gives an overflow whenever the low byte is LOW_TOP, else full word
    assign ovf_w  = st_r.ctl[BIT_WRAP8] ? (st_r.cnt[7:0] == LOW_TOP)
                                        : (st_r.cnt == WORD_TOP);

    // Buffers follow their holding stage while the array is disabled
    assign xfer_w = !st_r.ctl[BIT_ENABLE] || (step_w && ovf_w);

    // ************************************************************
    // APB handshake terms
    // ************************************************************
    assign setup_w  = psel && !penable;
    assign done_w   = psel && penable && st_r.pready;
    assign wr_w     = done_w && pwrite;
    // Same edge that latches the returned byte, so snapshot and byte agree
    assign cl_rd_w  = setup_w && !pwrite && (paddr == ADR_CL);
    assign cmp_wr_w = {wr_w && (paddr == ADR_SNH), wr_w && (paddr == ADR_SNL)};

    // ************************************************************
    // Submodules
    // ************************************************************
    // Prescaler restarts whenever counting is held
    pcm_prescale u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run_w),
        .divisor (st_r.pcs),
        .tick    (tick_w)
    );

    // One buffered byte per compare half
    genvar g;
    for (g = 0; g < 2; g++) begin : g_cmp
        pcm_dbuf #(.W(8)) u_buf (
            .pclk    (pclk),
            .presetn (presetn),
            .wr      (cmp_wr_w[g]),
            .wdata   (pwdata[7:0]),
            .xfer    (xfer_w),
            .hold    (),
            .active  (cmp_act_w[g*8 +: 8])
        );
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [7:0] rd_byte;   // Addressed byte
        logic       hit;       // Address is mapped
        rd_byte = 8'h00;
        hit     = 1'b1;
        st_nxt  = st_r;

        // Read decode; compare holding stages are write-only here
        unique case (paddr)
            ADR_MODE: rd_byte = st_r.ctl;
            ADR_PCS:  rd_byte = st_r.pcs;
            ADR_CH:   rd_byte = st_r.cnt[15:8];
            ADR_CL:   rd_byte = st_r.cnt[7:0];
            ADR_RLH:  rd_byte = st_r.rlh;
            ADR_RLL:  rd_byte = st_r.rll;
            ADR_SNH:  rd_byte = st_r.snap[15:8];
            ADR_SNL:  rd_byte = st_r.snap[7:0];
            default:  hit     = 1'b0;
        endcase

        // Answer one cycle after setup; data frozen until next setup
        st_nxt.pready  = setup_w;
        st_nxt.pslverr = setup_w && !hit;
        if (setup_w) begin
            st_nxt.prdata = {24'h000000, rd_byte};
        end

        // Register writes; count bytes are read-only and ignore writes
        if (wr_w) begin
            unique case (paddr)
                ADR_MODE: st_nxt.ctl = pwdata[7:0];
                ADR_PCS:  st_nxt.pcs = pwdata[7:0];
                ADR_RLH:  st_nxt.rlh = pwdata[7:0];
                ADR_RLL:  st_nxt.rll = pwdata[7:0];
                default:  st_nxt.ctl = st_r.ctl;
            endcase
        end

        // Counter: disabled means held at zero
        if (!st_r.ctl[BIT_ENABLE]) begin
            st_nxt.cnt = RST_CNT;
        end else if (step_w) begin
            if (ovf_w && st_r.ctl[BIT_RELOAD]) begin
                // Auto-reload: 8-bit mode keeps the high byte untouched
                if (st_r.ctl[BIT_WIDTH8]) begin
                    st_nxt.cnt = {st_r.cnt[15:8], st_r.rll};
                end else begin
                    st_nxt.cnt = {st_r.rlh, st_r.rll};
                end
            end else if (st_r.ctl[BIT_WIDTH8]) begin
                // 8-bit counting wraps inside the low byte
                st_nxt.cnt = {st_r.cnt[15:8], st_r.cnt[7:0] + 8'h01};
            end else begin
                // Free-run: plain increment, rolls over naturally
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end

        // Requests are single-cycle pulses from the step that caused them
        st_nxt.ovf_irq = step_w && ovf_w && st_r.ctl[BIT_OVF_IE];
        st_nxt.cmp_irq = step_w && st_r.ctl[BIT_CMP_IE] &&
                         (st_nxt.cnt == cmp_act_w);

        // Snapshot from a low-byte read or a comparator event; a later
        // capture would tear the high byte against the low byte returned
        if (cl_rd_w || (comparator_event && st_r.ctl[BIT_CMP_TRIG])) begin
            st_nxt.snap = st_r.cnt;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{ctl: RST_MODE, pcs: RST_PCS, cnt: RST_CNT,
                      rlh: RST_BYTE, rll: RST_BYTE, snap: RST_CNT,
                      prdata: 32'h00000000, pready: 1'b0,
                      pslverr: 1'b0, ovf_irq: 1'b0, cmp_irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign prdata       = st_r.prdata;
    assign pready       = st_r.pready;
    assign pslverr      = st_r.pslverr;
    assign overflow_irq = st_r.ovf_irq;
    assign compare_irq  = st_r.cmp_irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    apb_ready_a: assert property (setup_w |=> pready ##1 !pready)
        else $error("APB answer not exactly one access cycle");

    disable_clear_a: assert property (!st_r.ctl[BIT_ENABLE] |=> st_r.cnt == RST_CNT)
        else $error("count not cleared while disabled");

    idle_hold_a: assert property ((st_r.ctl[BIT_ENABLE] && st_r.ctl[BIT_IDLE_STOP]
        && idle_mode) |=> st_r.cnt == $past(st_r.cnt))
        else $error("count moved while stopped in idle");

    count_step_a: assert property ((step_w && !ovf_w && !st_r.ctl[BIT_WIDTH8])
        |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
        else $error("count did not advance by one");

    reload_word_a: assert property ((step_w && ovf_w && st_r.ctl[BIT_RELOAD]
        && !st_r.ctl[BIT_WIDTH8]) |=> st_r.cnt == {$past(st_r.rlh), $past(st_r.rll)})
        else $error("16-bit reload value not loaded");

    width8_hold_a: assert property ((step_w && st_r.ctl[BIT_WIDTH8])
        |=> st_r.cnt[15:8] == $past(st_r.cnt[15:8]))
        else $error("high byte changed in 8-bit mode");

    ovf_irq_a: assert property (overflow_irq
        |-> $past(step_w) && $past(ovf_w) && $past(st_r.ctl[BIT_OVF_IE]))
        else $error("overflow request without enabled overflow");

    cmp_irq_a: assert property (compare_irq |-> $past(st_r.ctl[BIT_CMP_IE])
        && st_r.cnt == $past(cmp_act_w))
        else $error("match request without enabled match");

    snap_read_a: assert property (cl_rd_w |=> st_r.snap == $past(st_r.cnt))
        else $error("low-byte read did not snapshot the count");

    cmp_snap_a: assert property ((comparator_event && !st_r.ctl[BIT_CMP_TRIG]
        && !cl_rd_w) |=> st_r.snap == $past(st_r.snap))
        else $error("comparator event snapshot while disabled");

endmodule : pcm_main_counter

/* core/pcm_pkg.sv */
// ****************************************************************
// Main counter package: register map, field positions, resets
// ****************************************************************
package pcm_pkg;

    // ************************************************************
    // Register indices and byte addresses (byte address = 4 x index)
    // ************************************************************
    localparam int unsigned      ADDR_W   = 18;        // APB address width used
    localparam logic [15:0]      IDX_MODE = 16'h00d1;  // counter_mode_control
    localparam logic [15:0]      IDX_PCS  = 16'ha0a5;  // counter_clock_prescale
    localparam logic [15:0]      IDX_CH   = 16'h00e9;  // counter_high_byte
    localparam logic [15:0]      IDX_CL   = 16'h00d9;  // counter_low_byte
    localparam logic [15:0]      IDX_RLH  = 16'ha0a7;  // reload_high_register
    localparam logic [15:0]      IDX_RLL  = 16'ha0a6;  // reload_low_register
    localparam logic [15:0]      IDX_SNH  = 16'h00f3;  // snapshot_high / compare_high
    localparam logic [15:0]      IDX_SNL  = 16'h00f2;  // snapshot_low / compare_low

    localparam logic [ADDR_W-1:0] ADR_MODE = {IDX_MODE, 2'b00}; // Byte addresses
    localparam logic [ADDR_W-1:0] ADR_PCS  = {IDX_PCS, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_CH   = {IDX_CH, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_CL   = {IDX_CL, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_RLH  = {IDX_RLH, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_RLL  = {IDX_RLL, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_SNH  = {IDX_SNH, 2'b00};
    localparam logic [ADDR_W-1:0] ADR_SNL  = {IDX_SNL, 2'b00};

    // ************************************************************
    // Field positions in counter_mode_control
    // ************************************************************
    localparam int unsigned BIT_IDLE_STOP = 7;  // idle_count_stop
    localparam int unsigned BIT_RELOAD    = 6;  // reload_mode_enable
    localparam int unsigned BIT_WIDTH8    = 5;  // byte_width_select
    localparam int unsigned BIT_WRAP8     = 4;  // low_byte_wrap_enable
    localparam int unsigned BIT_ENABLE    = 3;  // array_counter_enable
    localparam int unsigned BIT_OVF_IE    = 2;  // overflow_irq_enable
    localparam int unsigned BIT_CMP_IE    = 1;  // compare_match_irq_enable
    localparam int unsigned BIT_CMP_TRIG  = 0;  // comparator_snapshot_trigger

    // ************************************************************
    // Reset values and fixed patterns
    // ************************************************************
    localparam logic [7:0]  RST_MODE   = 8'h00;    // Mode register
    localparam logic [7:0]  RST_PCS    = 8'h00;    // Prescale divisor
    localparam logic [7:0]  RST_BYTE   = 8'h00;    // Reload, compare bytes
    localparam logic [15:0] RST_CNT    = 16'h0000; // Count and snapshot
    localparam logic [7:0]  LOW_TOP    = 8'hff;    // Low-byte overflow point
    localparam logic [15:0] WORD_TOP   = 16'hffff; // Full-word overflow point

    typedef logic [7:0] pcm_byte_t;                // One register byte

endpackage : pcm_pkg

/* core/pcm_prescale.sv */
`timescale 1ns/1ps
// ****************************************************************
// Prescaler: one tick every divisor+1 system clocks while running
// ****************************************************************
module pcm_prescale
    import pcm_pkg::*;
(
    input  wire logic             pclk,     // System clock
    input  wire logic             presetn,  // Async reset, active low
    input  wire logic             run,      // Counting allowed
    input  wire pcm_pkg::pcm_byte_t divisor, // Divide value minus one
    output logic                  tick      // One-cycle count pulse
);
    typedef struct packed {
        pcm_byte_t cnt;   // Clocks since last tick
        logic      tick;  // Registered tick
    } pcm_pre_s;

    pcm_pre_s st_r;       // Present state
    pcm_pre_s st_nxt;     // Next state

    // Restart from zero whenever counting is held so a resume is clean
    always_comb begin
        st_nxt = st_r;
        if (!run) begin
            st_nxt.cnt  = RST_BYTE;
            st_nxt.tick = 1'b0;
        end else if (st_r.cnt == divisor) begin
            st_nxt.cnt  = RST_BYTE;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt  = st_r.cnt + 8'h01;
            st_nxt.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    // A non-zero divisor never gives two ticks in a row
    tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && run && divisor != RST_BYTE) |=> !tick)
        else $error("prescaler ticked on consecutive clocks");

endmodule : pcm_prescale

/* tb/pcm_main_counter_test.sv */
`timescale 1ns/1ps
// ****************************************************************
// Main counter bench: APB driver, result monitor, scenarios
// ****************************************************************
module pcm_main_counter_test;
    import pcm_pkg::*;

    logic              pclk;             // System clock
    logic              presetn;          // Async reset, active low
    logic              psel;             // APB select
    logic              penable;          // APB access phase
    logic              pwrite;           // APB direction
    logic [ADDR_W-1:0] paddr;            // APB byte address
    logic [31:0]       pwdata;           // APB write data
    logic              idle_mode;        // Processor idle
    logic              comparator_event; // Comparator pulse
    logic [31:0]       prdata;           // APB read data
    logic              pready;           // APB ready
    logic              pslverr;          // APB error
    logic              overflow_irq;     // Overflow request
    logic              compare_irq;      // Match request
    logic [31:0]       rd;               // Last read data
    logic [64:0]       e;                // Popped note
    logic [64:0]       exp_q[$];         // Notes {mask, value, error}
    int                ovf_q[$];         // Cycle stamps of overflow pulses
    int                cmp_q[$];         // Cycle stamps of match pulses
    int                num_errors = 0;   // Mismatch count
    int                comparisons = 0;  // Compare count
    int                cyc = 0;          // Free cycle counter
    logic [7:0]        h;                // Frozen high byte
    logic [7:0]        l;                // Frozen low byte

    // Every register reads zero after reset
    localparam logic [ADDR_W-1:0] ADRS[8] = '{ADR_MODE, ADR_PCS, ADR_CH, ADR_CL,
                                              ADR_RLH, ADR_RLL, ADR_SNH, ADR_SNL};
    // Overflow spacing cases: mode, prescale, reload bytes, clocks between
    localparam logic [7:0] T_MODE[4] = '{8'h1c, 8'h4c, 8'h7c, 8'h3c};
    localparam logic [7:0] T_PCS[4]  = '{8'h03, 8'h00, 8'h00, 8'h01};
    localparam logic [7:0] T_RLH[4]  = '{8'h00, 8'hff, 8'h55, 8'h00};
    localparam logic [7:0] T_RLL[4]  = '{8'h00, 8'h00, 8'h80, 8'h00};
    localparam int         T_INT[4]  = '{1024, 256, 128, 512};

    always #2.5 pclk = ~pclk;

    pcm_main_counter u_pcm_main_counter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .idle_mode(idle_mode),
        .comparator_event(comparator_event), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .overflow_irq(overflow_irq), .compare_irq(compare_irq));

    // ************************************************************
    // Reporting
    // ************************************************************
    task print_verdict;
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        num_errors++;
    endtask : fail

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) fail(m);
    endtask : chk

    // ************************************************************
    // Monitor: stamps request pulses, checks each completed transfer
    // ************************************************************
    always @(posedge pclk) begin
        cyc++;
        if (overflow_irq === 1'b1) ovf_q.push_back(cyc);
        if (compare_irq === 1'b1) cmp_q.push_back(cyc);
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("transfer without note");
            end else begin
                e = exp_q.pop_front();
                chk(prdata & e[64:33], e[32:1], "read data");
                chk({31'h0, pslverr}, {31'h0, e[0]}, "error response");
            end
        end
    end

    // ************************************************************
    // APB master: request held until ready is sampled high
    // ************************************************************
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
             input logic [31:0] m, input logic [7:0] v, input logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        exp_q.push_back({m, 24'h0, v, err});
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            fail("no ready");
            print_verdict();
        end
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 32'h0, 8'h00, 1'b0);
    endtask : wr

    // Full check of the read word
    task rdx(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        apb(1'b0, a, 8'h00, 32'hffffffff, v, 1'b0);
    endtask : rdx

    // Byte unknown ahead, upper bits must be zero
    task rdc(input logic [ADDR_W-1:0] a);
        apb(1'b0, a, 8'h00, 32'hffffff00, 8'h00, 1'b0);
    endtask : rdc

    // Bounded wait until n pulses of one kind were stamped
    task wait_q(input logic c, input int n, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((c ? cmp_q.size() : ovf_q.size()) >= n) break;
            @(posedge pclk);
        end
        if (i == lim) begin
            fail("request pulse missing");
            print_verdict();
        end
    endtask : wait_q

    task pulse_cmp;
        @(posedge pclk);
        comparator_event <= 1'b1;
        @(posedge pclk);
        comparator_event <= 1'b0;
    endtask : pulse_cmp

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int          i;
        logic [31:0] rv;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; idle_mode = 1'b0; comparator_event = 1'b0;
        void'($urandom(39));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) rdx(ADRS[i], 8'h00);
        apb(1'b0, 18'h00010, 8'h00, 32'hffffffff, 8'h00, 1'b1);
        apb(1'b1, 18'h00010, 8'h5a, 32'h0, 8'h00, 1'b1);
        // Random settings read back; enable kept off so the count stays zero
        rv = $urandom;
        rv[28] = 1'b1;
        wr(ADR_RLH, rv[7:0]);
        wr(ADR_RLL, rv[15:8]);
        wr(ADR_PCS, rv[23:16]);
        wr(ADR_MODE, rv[31:24] & 8'hf7);
        wr(ADR_CH, 8'h33);
        rdx(ADR_RLH, rv[7:0]);
        rdx(ADR_RLL, rv[15:8]);
        rdx(ADR_PCS, rv[23:16]);
        rdx(ADR_MODE, rv[31:24] & 8'hf7);
        rdx(ADR_CH, 8'h00);
        // Spacing of the second and third overflow, first period skipped
        for (i = 0; i < 4; i++) begin
            wr(ADR_MODE, 8'h00);
            wr(ADR_PCS, T_PCS[i]);
            wr(ADR_RLH, T_RLH[i]);
            wr(ADR_RLL, T_RLL[i]);
            ovf_q.delete();
            wr(ADR_MODE, T_MODE[i]);
            wait_q(1'b0, 3, 70000);
            chk(ovf_q[2] - ovf_q[1], T_INT[i], "overflow spacing");
        end
        // Idle stop holds the count, idle without stop keeps counting
        idle_mode <= 1'b1;
        wr(ADR_MODE, 8'h00);
        wr(ADR_MODE, 8'h88);
        repeat (40) @(posedge pclk);
        rdx(ADR_CL, 8'h00);
        wr(ADR_MODE, 8'h08);
        repeat (40) @(posedge pclk);
        rdc(ADR_CL);
        chk({31'h0, rd[7:0] !== 8'h00}, 32'h1, "idle counting");
        // Freeze the count by idle, then snapshot by reading the low byte
        idle_mode <= 1'b0;
        wr(ADR_MODE, 8'h89);
        repeat ($urandom_range(200, 20)) @(posedge pclk);
        idle_mode <= 1'b1;
        rdc(ADR_CH);
        h = rd[7:0];
        rdc(ADR_CL);
        l = rd[7:0];
        rdx(ADR_SNH, h);
        rdx(ADR_SNL, l);
        // Comparator pulse ignored while its trigger is off
        idle_mode <= 1'b0;
        wr(ADR_MODE, 8'h88);
        repeat (300) @(posedge pclk);
        idle_mode <= 1'b1;
        pulse_cmp();
        rdx(ADR_SNH, h);
        rdx(ADR_SNL, l);
        // Trigger on: snapshot must follow the new frozen count
        wr(ADR_MODE, 8'h89);
        pulse_cmp();
        rdc(ADR_SNL);
        l = rd[7:0];
        rdc(ADR_CH);
        rdx(ADR_SNH, rd[7:0]);
        rdx(ADR_CL, l);
        // Disabling clears the count
        wr(ADR_MODE, 8'h00);
        rdx(ADR_CH, 8'h00);
        rdx(ADR_CL, 8'h00);
        rdx(ADR_SNL, 8'h00);
        idle_mode <= 1'b0;
        // Match at 0x05; a new value waits for the next overflow
        wr(ADR_PCS, 8'h00);
        wr(ADR_SNH, 8'h00);
        wr(ADR_SNL, 8'h05);
        cmp_q.delete();
        ovf_q.delete();
        wr(ADR_MODE, 8'h3a);
        wait_q(1'b1, 1, 400);
        wr(ADR_SNL, 8'h10);
        wait_q(1'b1, 2, 400);
        chk(cmp_q[1] - cmp_q[0], 267, "match spacing");
        chk(ovf_q.size(), 0, "overflow request while off");
        wr(ADR_MODE, 8'h38);
        cmp_q.delete();
        repeat (300) @(posedge pclk);
        chk(cmp_q.size(), 0, "match request while off");
        // Snapshot of a running count must match the low byte just read
        rdc(ADR_CL);
        rdx(ADR_SNL, rd[7:0]);
        print_verdict();
    end

endmodule : pcm_main_counter_test
